// ===== design/tws_pkg.sv
// Shared constants and types for the two-wire control slave port
package tws_pkg;
  localparam logic [3:0] TWS_ADDR_FIXED = 4'hB;
  localparam logic [7:0] TWS_BLK_CTRL   = 8'h00;
  localparam logic [7:0] TWS_BLK_LUT    = 8'h01;
  localparam logic [7:0] TWS_ADDR_TOP   = 8'h3F;
  localparam logic [2:0] TWS_BIT_LAST   = 3'h7;
  localparam logic [2:0] TWS_BIT_FIRST  = 3'h0;

  typedef enum logic [2:0] {
    TWS_IDLE  = 3'b000,
    TWS_ADDR  = 3'b001,
    TWS_AACK  = 3'b011,
    TWS_WRX   = 3'b010,
    TWS_WACK  = 3'b110,
    TWS_RTX   = 3'b111,
    TWS_RACK  = 3'b101,
    TWS_HOLD  = 3'b100
  } tws_state_t;

  typedef enum logic [1:0] {
    TWS_PH_BLOCK = 2'h0,
    TWS_PH_BASE  = 2'h1,
    TWS_PH_DATA  = 2'h2
  } tws_phase_t;

  // Register-space access toward the decoder core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       lut;
    logic [7:0] addr;
    logic [7:0] data;
  } tws_reg_req_t;
endpackage : tws_pkg

// ===== design/tws_slave.sv
// Two-wire serial control slave port of the video decoder
`timescale 1ns/1ps
module tws_slave
  import tws_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         scl,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  input  wire logic [2:0]   address_select_pins,
  input  wire logic         port_select_n,
  output tws_reg_req_t      reg_req,
  input  wire logic [7:0]   reg_rdata
);
  // Two-stage synchronisers
  logic       scl_s1;
  logic       scl_s2;
  logic       scl_d;
  logic       sda_s1;
  logic       sda_s2;
  logic       sda_d;
  logic       sel_s1;
  logic       sel_s2;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
    end
    else
    begin
      scl_s1 <= scl;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
      sel_s1 <= port_select_n;
      sel_s2 <= sel_s1;
    end
  end

  wire active     = ~sel_s2;
  wire scl_rise   = scl_s2 & ~scl_d;
  wire scl_fall   = ~scl_s2 & scl_d;
  wire start_cond = active & scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_cond  = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire no_event   = active & ~stop_cond & ~start_cond;

  tws_state_t state;
  tws_phase_t phase;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic       lut_sel;
  logic [7:0] addr;
  logic       ack_drive;
  logic       tx_bit;
  logic       tx_en;
  logic       bad_byte;

  wire [7:0] rx_byte    = {shreg[6:0], sda_s2};
  wire       last_bit   = bitcnt == TWS_BIT_LAST;
  wire       addr_match = rx_byte[7:1] == {TWS_ADDR_FIXED, address_select_pins};
  wire       base_ok    = rx_byte <= TWS_ADDR_TOP;
  wire       blk_ok     = (rx_byte == TWS_BLK_CTRL) | (rx_byte == TWS_BLK_LUT);
  wire [7:0] next_addr  = (addr >= TWS_ADDR_TOP) ? TWS_ADDR_TOP : addr + 8'h01;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state     <= TWS_IDLE;
      phase     <= TWS_PH_BLOCK;
      shreg     <= 8'h00;
      bitcnt    <= TWS_BIT_FIRST;
      lut_sel   <= 1'b0;
      addr      <= 8'h00;
      ack_drive <= 1'b0;
      tx_bit    <= 1'b1;
      tx_en     <= 1'b0;
      bad_byte  <= 1'b0;
      reg_req   <= '0;
    end
    else
    begin
      reg_req.wr <= 1'b0;
      reg_req.rd <= 1'b0;
      if (!active || stop_cond)
      begin
        state     <= TWS_IDLE;
        ack_drive <= 1'b0;
        tx_en     <= 1'b0;
      end
      else if (start_cond)
      begin
        state     <= TWS_ADDR;
        bitcnt    <= TWS_BIT_FIRST;
        ack_drive <= 1'b0;
        tx_en     <= 1'b0;
      end
      else
      begin
        case (state)
          TWS_IDLE: ;
          TWS_ADDR, TWS_WRX:
          begin
            if (scl_rise)
            begin
              shreg  <= rx_byte;
              bitcnt <= bitcnt + 3'h1;
            end
            if (scl_rise && last_bit)
            begin
              if (state == TWS_ADDR)
              begin
                state    <= TWS_AACK;
                bad_byte <= ~addr_match;
                if (addr_match && rx_byte[0])
                  reg_req.rd <= 1'b1;
                reg_req.lut  <= lut_sel;
                reg_req.addr <= addr;
                phase        <= TWS_PH_BLOCK;
              end
              else
              begin
                state <= TWS_WACK;
                case (phase)
                  TWS_PH_BLOCK:
                  begin
                    bad_byte <= ~blk_ok;
                    lut_sel  <= rx_byte == TWS_BLK_LUT;
                    phase    <= TWS_PH_BASE;
                  end
                  TWS_PH_BASE:
                  begin
                    bad_byte <= ~base_ok;
                    if (base_ok)
                      addr <= rx_byte;
                    phase <= TWS_PH_DATA;
                  end
                  default:
                  begin
                    bad_byte     <= 1'b0;
                    reg_req.wr   <= 1'b1;
                    reg_req.lut  <= lut_sel;
                    reg_req.addr <= addr;
                    reg_req.data <= rx_byte;
                    addr         <= next_addr;
                  end
                endcase
              end
            end
          end
          TWS_AACK, TWS_WACK:
          begin
            // Drive ack from the falling edge after bit 8 to the one after the ninth
            if (scl_fall && bitcnt == TWS_BIT_FIRST)
            begin
              ack_drive <= ~bad_byte;
              bitcnt    <= bitcnt + 3'h1;
            end
            else if (scl_fall)
            begin
              ack_drive <= 1'b0;
              bitcnt    <= TWS_BIT_FIRST;
              if (bad_byte)
                state <= TWS_HOLD;
              else if (state == TWS_AACK && shreg[0])
              begin
                state  <= TWS_RTX;
                tx_en  <= 1'b1;
                tx_bit <= reg_rdata[7];
                shreg  <= {reg_rdata[6:0], 1'b0};
                addr   <= next_addr;
              end
              else
                state <= TWS_WRX;
            end
          end
          TWS_RTX:
          begin
            if (scl_fall)
            begin
              bitcnt <= bitcnt + 3'h1;
              if (last_bit)
              begin
                tx_en <= 1'b0;
                state <= TWS_RACK;
              end
              else
              begin
                tx_bit <= shreg[7];
                shreg  <= {shreg[6:0], 1'b0};
              end
            end
          end
          TWS_RACK:
          begin
            if (scl_rise)
            begin
              if (sda_s2)
                state <= TWS_HOLD;
              else
              begin
                reg_req.rd   <= 1'b1;
                reg_req.lut  <= lut_sel;
                reg_req.addr <= addr;
              end
            end
            else if (scl_fall)
            begin
              state  <= TWS_RTX;
              bitcnt <= TWS_BIT_FIRST;
              tx_en  <= 1'b1;
              tx_bit <= reg_rdata[7];
              shreg  <= {reg_rdata[6:0], 1'b0};
              addr   <= next_addr;
            end
          end
          TWS_HOLD: ;
          default: state <= TWS_IDLE;
        endcase
      end
    end
  end

  // Open-drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = ack_drive | (tx_en & ~tx_bit);

  start_ack_a: assert property (@(posedge clk) disable iff (rst)
    start_cond |=> state == TWS_ADDR) else $error("start not taken");
  stop_idle_a: assert property (@(posedge clk) disable iff (rst)
    stop_cond |=> state == TWS_IDLE) else $error("stop not taken");
  sel_release_a: assert property (@(posedge clk) disable iff (rst)
    ##1 (!active && $past(!active)) |-> !sda_oe) else $error("drive while deselected");
  addr_sat_a: assert property (@(posedge clk) disable iff (rst)
    addr <= TWS_ADDR_TOP) else $error("address above top");
  hold_release_a: assert property (@(posedge clk) disable iff (rst)
    state == TWS_HOLD |-> !sda_oe) else $error("hold drives data");
  nack_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state == TWS_RACK && scl_rise && sda_s2 && !stop_cond && !start_cond && active)
    |=> state == TWS_HOLD) else $error("master nack ignored");
  bad_noack_a: assert property (@(posedge clk) disable iff (rst)
    (bad_byte && (state == TWS_AACK || state == TWS_WACK)) |-> !ack_drive)
    else $error("ack on refused byte");
  wr_addr_a: assert property (@(posedge clk) disable iff (rst)
    reg_req.wr |-> addr == ((reg_req.addr >= TWS_ADDR_TOP) ? TWS_ADDR_TOP
                            : reg_req.addr + 8'h01)) else $error("no advance");
  blk_lut_a: assert property (@(posedge clk) disable iff (rst)
    (state == TWS_WRX && phase == TWS_PH_BLOCK && scl_rise && last_bit && no_event
     && rx_byte == TWS_BLK_LUT) |=> lut_sel) else $error("lookup block not chosen");
  blk_ctrl_a: assert property (@(posedge clk) disable iff (rst)
    (state == TWS_WRX && phase == TWS_PH_BLOCK && scl_rise && last_bit && no_event
     && rx_byte == TWS_BLK_CTRL) |=> !lut_sel) else $error("control block not chosen");
  base_refuse_a: assert property (@(posedge clk) disable iff (rst)
    (state == TWS_WRX && phase == TWS_PH_BASE && scl_rise && last_bit && no_event
     && rx_byte > TWS_ADDR_TOP) |=> bad_byte) else $error("high base accepted");
  addr_nack_a: assert property (@(posedge clk) disable iff (rst)
    (state == TWS_ADDR && scl_rise && last_bit && no_event && rx_byte[7:1] !=
     {TWS_ADDR_FIXED, address_select_pins}) |=> bad_byte) else $error("foreign address");
  data_ack_a: assert property (@(posedge clk) disable iff (rst)
    (state == TWS_WACK && !bad_byte && scl_fall && bitcnt == TWS_BIT_FIRST && no_event)
    |=> ack_drive) else $error("write byte not acknowledged");
  read_start_a: assert property (@(posedge clk) disable iff (rst)
    (state == TWS_AACK && !bad_byte && shreg[0] && scl_fall && bitcnt != TWS_BIT_FIRST
     && no_event) |=> (state == TWS_RTX && tx_en)) else $error("read not started");
  read_next_a: assert property (@(posedge clk) disable iff (rst)
    (state == TWS_RACK && scl_rise && !sda_s2 && no_event) |=> reg_req.rd)
    else $error("next read not fetched");
  idle_release_a: assert property (@(posedge clk) disable iff (rst)
    state == TWS_IDLE |-> !sda_oe) else $error("idle drives data");
endmodule : tws_slave

// ===== bench/tws_master.sv
// Two-wire bus master model with open-drain data
`timescale 1ns/1ps
module tws_master (
  input  wire logic clk,
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  task automatic start();
    w(2);
    sda_pull = 1'b0;
    w(2);
    scl = 1'b1;
    w(4);
    sda_pull = 1'b1;
    w(4);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    w(2);
    sda_pull = 1'b1;
    w(2);
    scl = 1'b1;
    w(4);
    sda_pull = 1'b0;
    w(4);
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    w(2);
    sda_pull = ~b;
    w(2);
    scl = 1'b1;
    w(4);
    r   = sda;
    scl = 1'b0;
  endtask : bit_io
  task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                      output logic ao);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ai, ao);
  endtask : xfer
endmodule : tws_master

// ===== bench/tb_top.sv
// Testbench for the two-wire control slave port
`timescale 1ns/1ps
module tb_top;
  import tws_pkg::*;
  localparam logic [7:0] AW = {TWS_ADDR_FIXED, 3'h5, 1'b0};
  localparam logic [7:0] AR = AW | 8'h01;
  logic         clk;
  logic         rst;
  logic         port_select_n;
  logic [2:0]   address_select_pins;
  logic         scl;
  logic         sda_pull;
  logic         sda_out;
  logic         sda_oe;
  wire          sda;
  tws_reg_req_t reg_req;
  logic [7:0]   mem [0:255];
  int           n_errors = 0;
  int           checks = 0;
  int           cyc = 0;
  logic [7:0]   rx;
  logic         ak;
  assign sda = ~(sda_pull | (sda_oe & ~sda_out));
  tws_slave tws_slave_i (
    .clk                 (clk),
    .rst                 (rst),
    .scl                 (scl),
    .sda_in              (sda),
    .sda_out             (sda_out),
    .sda_oe              (sda_oe),
    .address_select_pins (address_select_pins),
    .port_select_n       (port_select_n),
    .reg_req             (reg_req),
    .reg_rdata           (mem[{reg_req.lut, reg_req.addr[6:0]}])
  );
  tws_master tws_master_i (
    .clk      (clk),
    .scl      (scl),
    .sda_pull (sda_pull),
    .sda      (sda)
  );
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (reg_req.wr)
      mem[{reg_req.lut, reg_req.addr[6:0]}] <= reg_req.data;
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic head(input logic [7:0] a, input logic e);
    tws_master_i.start();
    tws_master_i.xfer(a, 1'b1, rx, ak);
    chk(8'(ak), 8'(e));
  endtask : head
  task automatic wb(input logic [7:0] d, input logic e);
    tws_master_i.xfer(d, 1'b1, rx, ak);
    chk(8'(ak), 8'(e));
  endtask : wb
  task automatic rb(input logic [7:0] e, input logic nk);
    tws_master_i.xfer(8'hFF, nk, rx, ak);
    chk(rx, e);
  endtask : rb
  task automatic ptr(input logic [7:0] blk, input logic [7:0] base);
    head(AW, 1'b0);
    wb(blk, 1'b0);
    wb(base, 1'b0);
  endtask : ptr
  task automatic t_addr();
    for (int i = 0; i < 8; i++)
    begin
      head({TWS_ADDR_FIXED, 3'(i), 1'b0}, 1'(i != 5));
      tws_master_i.stop();
    end
    head(AW ^ 8'h80, 1'b1);
    tws_master_i.stop();
    port_select_n = 1'b1;
    head(AW, 1'b1);
    tws_master_i.stop();
    port_select_n = 1'b0;
    $display("t_addr done");
  endtask : t_addr
  task automatic t_write();
    ptr(TWS_BLK_CTRL, 8'h3E);
    wb(8'hA1, 1'b0);
    wb(8'hB2, 1'b0);
    wb(8'hC3, 1'b0);
    tws_master_i.stop();
    ptr(TWS_BLK_CTRL, 8'h3D);
    tws_master_i.stop();
    head(AR, 1'b0);
    rb(8'h3D, 1'b0);
    rb(8'hA1, 1'b0);
    rb(8'hC3, 1'b0);
    rb(8'hC3, 1'b1);
    tws_master_i.bit_io(1'b1, ak);
    chk(8'(ak), 8'h01);
    tws_master_i.stop();
    $display("t_write done");
  endtask : t_write
  task automatic t_lut();
    ptr(TWS_BLK_LUT, 8'h05);
    wb(8'h77, 1'b0);
    ptr(TWS_BLK_LUT, 8'h05);
    head(AR, 1'b0);
    rb(8'h77, 1'b1);
    tws_master_i.stop();
    ptr(TWS_BLK_CTRL, 8'h05);
    head(AR, 1'b0);
    rb(8'h05, 1'b1);
    tws_master_i.stop();
    $display("t_lut done");
  endtask : t_lut
  task automatic t_refuse();
    head(AW, 1'b0);
    wb(8'h02, 1'b1);
    wb(8'h00, 1'b1);
    tws_master_i.stop();
    head(AW, 1'b0);
    wb(TWS_BLK_CTRL, 1'b0);
    wb(8'h40 | TWS_ADDR_TOP, 1'b1);
    wb(8'h99, 1'b1);
    tws_master_i.stop();
    $display("t_refuse done");
  endtask : t_refuse
  initial
  begin
    rst                 = 1'b1;
    port_select_n       = 1'b0;
    address_select_pins = 3'h5;
    foreach (mem[i])
      mem[i] = 8'(i);
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    t_addr();
    t_write();
    t_lut();
    t_refuse();
    complete_run();
  end
endmodule : tb_top
